// [mar_attr_resolver.sv]
`timescale 1ns/1ps
module mar_attr_resolver (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [mar_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic i_txn_valid,
  input wire mar_pkg::mar_attr_t i_txn_attr,
  input wire logic i_txn_secure,
  input wire logic i_txn_write,
  input wire logic i_glb_bypass,
  input wire mar_pkg::mar_attr_t i_s1_desc,
  input wire mar_pkg::mar_cfg_t i_s2_desc,
  output logic o_txn_valid,
  output mar_pkg::mar_attr_t o_txn_attr,
  output logic o_txn_fault
);
  import mar_pkg::*;

  logic [31:0] glb_reg;
  logic [31:0] s2c_reg;
  logic [31:0] s1ctl_reg;
  logic [31:0] s2ctl_reg;
  logic [31:0] cbar_reg;

  // reserved codes take their substitutes here, and the final fix-up maps reserved shareability to outer; storage keeps raw bits
  function automatic mar_cfg_t sub_cfg(input mar_cfg_t c);
    mar_cfg_t r;
    r = c;
    if (c.security_override_cfg == HINT_RSVD) begin
      r.security_override_cfg = CODE_HI;
    end
    if (c.read_alloc_hint_cfg == HINT_RSVD) begin
      r.read_alloc_hint_cfg = HINT_PASS;
    end
    if (c.write_alloc_hint_cfg == HINT_RSVD) begin
      r.write_alloc_hint_cfg = HINT_PASS;
    end
    if (c.transient_hint_cfg == HINT_RSVD) begin
      r.transient_hint_cfg = HINT_PASS;
    end
    if (c.insn_data_override_cfg == HINT_RSVD) begin
      r.insn_data_override_cfg = CODE_HI;
    end
    if (c.privilege_override_cfg == HINT_RSVD) begin
      r.privilege_override_cfg = CODE_LO;
    end
    if (c.shareability_cfg == SH_RSVD) begin
      r.shareability_cfg = SH_OUTER;
    end
    if (c.memory_type_field[1:0] == MEM_DEV && c.memory_type_field[3:2] != MEM_DEV) begin
      r.memory_type_field = 4'h0;
    end
    return r;
  endfunction

  // code 1x forces a value, 00 keeps current; inv flips codes where 10 means set
  function automatic logic pick(input logic cur, input logic [1:0] code, input logic inv);
    return code[1] ? (code[0] ^ inv) : cur;
  endfunction

  function automatic mar_attr_t override(input mar_attr_t a, input mar_cfg_t raw,
                                         input logic secure, input logic write,
                                         input logic ip_ok);
    mar_cfg_t c;
    mar_attr_t r;
    c = sub_cfg(raw);
    r = a;
    if (secure) begin
      r.ns = pick(a.ns, c.security_override_cfg, 1'b0);
    end
    r.ra = pick(a.ra, c.read_alloc_hint_cfg, 1'b1);
    r.wa = pick(a.wa, c.write_alloc_hint_cfg, 1'b1);
    r.trans = pick(a.trans, c.transient_hint_cfg, 1'b1);
    if (c.type_transform_enable) begin
      r.mem = c.memory_type_field;
      r.dev = c.dev;
    end
    r.sh = c.shareability_cfg;
    if (ip_ok) begin
      r.insn = pick(a.insn, c.insn_data_override_cfg, 1'b0);
      r.priv = pick(a.priv, c.privilege_override_cfg, 1'b0);
    end
    if (write) begin
      r.insn = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [1:0] min2(input logic [1:0] x, input logic [1:0] y);
    return (x < y) ? x : y;
  endfunction

  // memory type halves and shareability resolved on their own, lower code being the stronger one; ra/wa taken by stage 2 override codes
  function automatic mar_attr_t combine(input mar_attr_t s1, input mar_cfg_t s2);
    mar_attr_t r;
    r = s1;
    r.mem[3:2] = min2(s1.mem[3:2], s2.memory_type_field[3:2]);
    r.mem[1:0] = min2(s1.mem[1:0], s2.memory_type_field[1:0]);
    if (s1.mem == 4'h0 && s2.memory_type_field == 4'h0) begin
      r.dev = min2(s1.dev, s2.dev);
    end else if (s2.memory_type_field == 4'h0) begin
      r.dev = s2.dev;
    end
    r.sh = min2(s1.sh, s2.shareability_cfg);
    r.ra = pick(s1.ra, s2.read_alloc_hint_cfg, 1'b1);
    r.wa = pick(s1.wa, s2.write_alloc_hint_cfg, 1'b1);
    return r;
  endfunction

  // register port
  wire hit_glb = i_addr == OFF_GLB;
  wire hit_s2c = i_addr == OFF_S2C;
  wire hit_s1ctl = i_addr == OFF_S1CTL;
  wire hit_s2ctl = i_addr == OFF_S2CTL;
  wire hit_cbar = i_addr == OFF_CBAR;
  wire hit_stat = i_addr == OFF_STAT;
  wire wr_go = i_clk_en && i_wr_en;
  wire [31:0] wr_cfg = i_wr_data & WMASK_CFG;
  wire [31:0] wr_type = i_wr_data & (WMASK_CFG | WMASK_TYPE);
  wire [31:0] wr_m = i_wr_data & (WMASK_CFG | WMASK_M);
  wire [31:0] stat_word = {o_txn_fault, 17'h00000, o_txn_attr};
  wire [31:0] rd_mux = hit_glb ? glb_reg :
                       hit_s2c ? s2c_reg :
                       hit_s1ctl ? s1ctl_reg :
                       hit_s2ctl ? s2ctl_reg :
                       hit_cbar ? cbar_reg :
                       hit_stat ? stat_word : 32'h00000000;

  // raw bits stored and returned, substitutes applied only on use
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      glb_reg <= RST_CFG;
      s2c_reg <= RST_S2C;
      s1ctl_reg <= RST_CFG;
      s2ctl_reg <= RST_CFG;
      cbar_reg <= RST_CBAR;
    end else if (wr_go) begin
      if (hit_glb) glb_reg <= wr_cfg;
      if (hit_s2c) s2c_reg <= wr_type;
      if (hit_s1ctl) s1ctl_reg <= wr_m;
      if (hit_s2ctl) s2ctl_reg <= wr_m;
      if (hit_cbar) cbar_reg <= wr_type;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rd_data <= 32'h00000000;
    end else if (i_clk_en) begin
      o_rd_data <= i_rd_en ? rd_mux : 32'h00000000;
    end
  end

  // incoming markings with defaults for those the upstream bus lacks
  mar_attr_t in_attr;
  assign in_attr.ns = UP_HAS_NS ? i_txn_attr.ns : 1'b1;
  assign in_attr.ra = UP_HAS_ALLOC ? i_txn_attr.ra : 1'b1;
  assign in_attr.wa = UP_HAS_ALLOC ? i_txn_attr.wa : 1'b1;
  assign in_attr.mem = UP_HAS_MEM ? i_txn_attr.mem : MEM_WB_ALL;
  assign in_attr.dev = UP_HAS_MEM ? i_txn_attr.dev : DEV_STRICTEST;
  assign in_attr.sh = UP_HAS_SH ? i_txn_attr.sh : SH_NONE;
  assign in_attr.insn = UP_HAS_INSN ? i_txn_attr.insn : 1'b0;
  assign in_attr.priv = UP_HAS_PRIV ? i_txn_attr.priv : 1'b0;
  assign in_attr.trans = UP_HAS_TRANS ? i_txn_attr.trans : 1'b0;

  wire mar_cfg_t glb_cfg = mar_cfg_t'(glb_reg[CFG_W-1:0]);
  wire mar_cfg_t s2c_cfg = mar_cfg_t'(s2c_reg[CFG_W-1:0]);
  wire mar_cfg_t s1ctl_cfg = mar_cfg_t'(s1ctl_reg[CFG_W-1:0]);
  wire mar_cfg_t s2ctl_cfg = mar_cfg_t'(s2ctl_reg[CFG_W-1:0]);
  wire mar_cfg_t cbar_cfg = mar_cfg_t'(cbar_reg[CFG_W-1:0]);
  wire [1:0] s2c_type = s2c_reg[31:TYPE_LO];
  wire [1:0] cb_type = cbar_reg[31:TYPE_LO];
  wire s1_m = s1ctl_reg[M_BIT];
  wire s2_m = s2ctl_reg[M_BIT];
  wire is_translate = s2c_type == S2C_TRANSLATE;
  wire is_bypass = s2c_type == S2C_BYPASS;

  // the three sources of a first transformation
  wire mar_attr_t glb_attr = override(in_attr, glb_cfg, i_txn_secure, i_txn_write,
                                      1'b0);
  wire mar_attr_t byp_attr = override(in_attr, s2c_cfg, i_txn_secure, i_txn_write,
                                      1'b0);
  wire mar_attr_t s2c_attr = override(in_attr, s2c_cfg, i_txn_secure, i_txn_write,
                                      1'b1);

  // stage 1 result: with M set (and not stage 2 only), descriptor supplies all but instruction/data and privilege, which come from the stream entry
  mar_attr_t desc_attr;
  always_comb begin
    desc_attr = i_s1_desc;
    desc_attr.insn = s2c_attr.insn;
    desc_attr.priv = s2c_attr.priv;
    // a non-secure stream may never be turned secure by its descriptor
    desc_attr.ns = i_s1_desc.ns | !i_txn_secure;
  end
  wire mar_attr_t ctl_attr = override(s2c_attr, s1ctl_cfg, i_txn_secure, i_txn_write,
                                      1'b0);
  wire mar_attr_t s1_res = (cb_type == CB_S2ONLY) ? s2c_attr :
                           s1_m ? desc_attr : ctl_attr;

  // stage 2 source; a disabled stage 2 lends its control register hints
  wire mar_cfg_t s2_src = (cb_type == CB_S1_S2BYP) ? cbar_cfg :
                          s2_m ? i_s2_desc : s2ctl_cfg;
  wire mar_cfg_t s2_eff = sub_cfg(s2_src);
  wire mar_attr_t comb_attr = combine(s1_res, s2_eff);

  wire mar_attr_t pre_attr = i_glb_bypass ? glb_attr :
                             is_bypass ? byp_attr : comb_attr;
  wire txn_fault = !i_glb_bypass && !is_translate && !is_bypass;

  // shareability fix-up is applied last so no source can undo it
  wire dev_type = pre_attr.mem[3:2] == MEM_DEV || pre_attr.mem[1:0] == MEM_DEV;
  wire nc_type = pre_attr.mem[3:2] == MEM_NC || pre_attr.mem[1:0] == MEM_NC;
  mar_attr_t fin_attr;
  always_comb begin
    fin_attr = pre_attr;
    if (dev_type || nc_type || pre_attr.sh == SH_RSVD) begin
      fin_attr.sh = SH_OUTER;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_txn_valid <= 1'b0;
      o_txn_attr <= '0;
      o_txn_fault <= 1'b0;
    end else if (i_clk_en) begin
      o_txn_valid <= i_txn_valid;
      if (i_txn_valid) begin
        o_txn_attr <= fin_attr;
        o_txn_fault <= txn_fault;
      end
    end
  end

  AST_DEV_OUTER:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_txn_valid && (o_txn_attr.mem[3:2] == MEM_DEV || o_txn_attr.mem[1:0] == MEM_DEV)
      |-> o_txn_attr.sh == SH_OUTER)
    else $error("device memory left without outer shareability");

  AST_NC_OUTER:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && nc_type |=> o_txn_attr.sh == SH_OUTER)
    else $error("non-cacheable memory left without outer shareability");

  AST_WRITE_DATA:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && i_txn_write |=> o_txn_valid && !o_txn_attr.insn)
    else $error("write leaves marked as instruction");

  AST_NONSEC_KEEP:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && !i_txn_secure && i_txn_attr.ns |=> o_txn_attr.ns)
    else $error("non-secure transaction turned secure");

  AST_GLB_NOFAULT:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && i_glb_bypass && glb_cfg.shareability_cfg == SH_NONE
      && !dev_type && !nc_type |=> !o_txn_fault && o_txn_attr.sh == SH_NONE)
    else $error("global bypass not governed by global control");

  AST_MEM_STRONGER:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      comb_attr.mem[3:2] <= s1_res.mem[3:2] && comb_attr.mem[1:0] <= s1_res.mem[1:0]
      && comb_attr.mem[1:0] <= s2_eff.memory_type_field[1:0])
    else $error("combine weakened the memory type");

  AST_SH_STRONGER:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      comb_attr.sh <= s1_res.sh && comb_attr.sh <= s2_eff.shareability_cfg)
    else $error("combine weakened shareability");

  AST_HINT_PASS:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s2_eff.read_alloc_hint_cfg == HINT_PASS |-> comb_attr.ra == s1_res.ra)
    else $error("pass-through read hint not taken from stage 1");

  AST_DESC_IP:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      cb_type != CB_S2ONLY && s1_m |-> s1_res.insn == s2c_attr.insn
      && s1_res.priv == s2c_attr.priv && s1_res.mem == i_s1_desc.mem)
    else $error("stage 1 descriptor handling wrong");

  AST_READBACK:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_wr_en && hit_glb ##1 i_clk_en && i_rd_en && hit_glb
      |=> o_rd_data == ($past(i_wr_data, 2) & WMASK_CFG))
    else $error("configuration field not read back as written");

  AST_RD_IDLE:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && !i_rd_en |=> o_rd_data == 32'h00000000)
    else $error("read data not zero outside a read");

  AST_TRANS_RAZ:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      glb_reg[1:0] == 2'h0 && s2c_reg[1:0] == 2'h0 && cbar_reg[1:0] == 2'h0)
    else $error("transient field stored though downstream cannot carry it");

  AST_BYP_NOFAULT:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && !i_glb_bypass && is_bypass |=> !o_txn_fault)
    else $error("bypass stream entry raised a fault");

  AST_TYPE_FAULT:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && !i_glb_bypass && !is_translate && !is_bypass
      |=> o_txn_fault)
    else $error("fault type stream entry passed without fault");

  AST_HINT_WPASS:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s2_eff.write_alloc_hint_cfg == HINT_PASS |-> comb_attr.wa == s1_res.wa)
    else $error("pass-through write hint not taken from stage 1");

  AST_HINT_TAKE:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s2_eff.read_alloc_hint_cfg[1] |-> comb_attr.ra == !s2_eff.read_alloc_hint_cfg[0])
    else $error("stage 2 read hint not applied");

  AST_SUB_NS:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && i_glb_bypass && i_txn_secure
      && glb_reg[7:6] == HINT_RSVD |=> o_txn_attr.ns)
    else $error("reserved security code not treated as non-secure");

  AST_S2_ONLY:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      cb_type == CB_S2ONLY |-> s1_res == s2c_attr)
    else $error("stage 2 only context ignored stream entry result");

  AST_MT_APPLY:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clk_en && i_txn_valid && i_glb_bypass && glb_cfg.type_transform_enable
      && glb_cfg.memory_type_field[1:0] == MEM_DEV |=> o_txn_attr.mem == 4'h0)
    else $error("memory type transform not applied");

  AST_CE_HOLD:
    assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !i_clk_en |=> $stable(o_txn_attr) && $stable(o_rd_data) && $stable(o_txn_valid))
    else $error("outputs moved while clock enable low");
endmodule

// [mar_far_side.sv]
`timescale 1ns/1ps
module mar_far_side (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_txn_valid,
  input wire mar_pkg::mar_attr_t i_txn_attr,
  output logic [15:0] o_seen,
  output mar_pkg::mar_attr_t o_last
);
  import mar_pkg::*;
  // downstream sink with no backpressure: the resolver never waits on it
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_seen <= 16'h0000;
      o_last <= '0;
    end else if (i_txn_valid) begin
      o_seen <= o_seen + 16'h0001;
      o_last <= i_txn_attr;
    end
  end
endmodule

// [mar_pkg.sv]
package mar_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_GLB = 8'h00;
  localparam logic [7:0] OFF_S2C = 8'h04;
  localparam logic [7:0] OFF_S1CTL = 8'h08;
  localparam logic [7:0] OFF_S2CTL = 8'h0C;
  localparam logic [7:0] OFF_CBAR = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam int CFG_W = 21;
  localparam int M_BIT = 31;
  localparam int TYPE_LO = 30;
  localparam logic DOWN_HAS_TRANS = 1'b0;
  localparam logic [31:0] WMASK_CFG = DOWN_HAS_TRANS ? 32'h001FFFFF : 32'h001FFFFC;
  localparam logic [31:0] WMASK_TYPE = 32'hC0000000;
  localparam logic [31:0] WMASK_M = 32'h80000000;
  localparam logic [31:0] RST_CFG = 32'h00000000;
  localparam logic [31:0] RST_S2C = 32'h40000000;
  localparam logic [31:0] RST_CBAR = 32'h000F3000;
  localparam logic [1:0] HINT_PASS = 2'h0;
  localparam logic [1:0] HINT_RSVD = 2'h1;
  localparam logic [1:0] CODE_HI = 2'h3;
  localparam logic [1:0] CODE_LO = 2'h2;
  localparam logic [1:0] SH_RSVD = 2'h0;
  localparam logic [1:0] SH_OUTER = 2'h1;
  localparam logic [1:0] SH_NONE = 2'h3;
  localparam logic [1:0] MEM_DEV = 2'h0;
  localparam logic [1:0] MEM_NC = 2'h1;
  localparam logic [3:0] MEM_WB_ALL = 4'hF;
  localparam logic [1:0] DEV_STRICTEST = 2'h0;
  localparam logic [1:0] S2C_TRANSLATE = 2'h0;
  localparam logic [1:0] S2C_BYPASS = 2'h1;
  localparam logic [1:0] CB_S1_S2BYP = 2'h0;
  localparam logic [1:0] CB_S2ONLY = 2'h1;
  localparam logic UP_HAS_NS = 1'b1;
  localparam logic UP_HAS_ALLOC = 1'b1;
  localparam logic UP_HAS_MEM = 1'b1;
  localparam logic UP_HAS_SH = 1'b1;
  localparam logic UP_HAS_INSN = 1'b1;
  localparam logic UP_HAS_PRIV = 1'b1;
  localparam logic UP_HAS_TRANS = 1'b1;

  typedef struct packed {
    logic type_transform_enable;
    logic [3:0] memory_type_field;
    logic [1:0] dev;
    logic [1:0] shareability_cfg;
    logic [1:0] read_alloc_hint_cfg;
    logic [1:0] write_alloc_hint_cfg;
    logic [1:0] security_override_cfg;
    logic [1:0] insn_data_override_cfg;
    logic [1:0] privilege_override_cfg;
    logic [1:0] transient_hint_cfg;
  } mar_cfg_t;

  typedef struct packed {
    logic ns;
    logic ra;
    logic wa;
    logic [3:0] mem;
    logic [1:0] dev;
    logic [1:0] sh;
    logic insn;
    logic priv;
    logic trans;
  } mar_attr_t;
endpackage

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  import mar_pkg::*;
  logic clk, rst, clk_en, wr, rd, tv, tsec, twr, byp, ov, fault;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  mar_attr_t tattr, s1d, oattr, last;
  mar_cfg_t s2d;
  logic [15:0] seen;
  int mismatches, n_compared, n_txn;

  mar_attr_resolver u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata),
    .i_txn_valid(tv), .i_txn_attr(tattr), .i_txn_secure(tsec), .i_txn_write(twr),
    .i_glb_bypass(byp), .i_s1_desc(s1d), .i_s2_desc(s2d), .o_txn_valid(ov),
    .o_txn_attr(oattr), .o_txn_fault(fault)
  );
  mar_far_side u_far (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_txn_valid(ov), .i_txn_attr(oattr),
    .o_seen(seen), .o_last(last)
  );

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ns/ra/wa packed as one 3-bit group to keep call sites short; transient always 0
  function mar_attr_t mk(input logic [2:0] nrw, input logic [3:0] mem, input logic [1:0] dev,
                         input logic [1:0] sh, input logic [1:0] ip);
    return {nrw, mem, dev, sh, ip, 1'h0};
  endfunction

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask

  task setd(input mar_attr_t s1, input logic [20:0] s2);
    @(posedge clk);
    s1d <= s1;
    s2d <= mar_cfg_t'(s2);
  endtask

  task tx(input mar_attr_t a, input logic sec, input logic w, input logic gb,
          input mar_attr_t exp);
    @(posedge clk);
    tv <= 1'h1;
    tattr <= a;
    tsec <= sec;
    twr <= w;
    byp <= gb;
    @(posedge clk);
    tv <= 1'h0;
    #1;
    n_txn++;
    chk({31'h0, ov}, 32'h1);
    chk({31'h0, fault}, 32'h0);
    chk({18'h0, oattr}, {18'h0, exp});
  endtask

  task t_regs;
    logic [31:0] d;
    rd_reg(OFF_S2C, d);
    chk(d, RST_S2C);
    rd_reg(OFF_CBAR, d);
    chk(d, RST_CBAR);
    wr_reg(OFF_GLB, 32'hFFFFFFFF);
    rd_reg(OFF_GLB, d);
    chk(d, WMASK_CFG);
    wr_reg(OFF_S1CTL, 32'hFFFFFFFF);
    rd_reg(OFF_S1CTL, d);
    chk(d, WMASK_M | WMASK_CFG);
    wr_reg(8'h20, 32'hFFFFFFFF);
    rd_reg(8'h20, d);
    chk(d, 32'h00000000);
    wr_reg(OFF_GLB, 32'h00000040);
    rd_reg(OFF_GLB, d);
    chk(d, 32'h00000040);
    $display("test regs done");
  endtask

  task t_glb;
    // stream entry would clear read allocate; global bypass must not see it
    wr_reg(OFF_S2C, 32'h40000C00);
    tx(mk(3'h3, 4'hA, 2'h0, 2'h2, 2'h0), 1'h1, 1'h0, 1'h1, mk(3'h7, 4'hA, 2'h0, 2'h1, 2'h0));
    wr_reg(OFF_GLB, 32'h00000080);
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h1, mk(3'h7, 4'hA, 2'h0, 2'h1, 2'h0));
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h1, 1'h0, 1'h1, mk(3'h3, 4'hA, 2'h0, 2'h1, 2'h0));
    wr_reg(OFF_GLB, 32'h00102000);
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h1, mk(3'h7, 4'h0, 2'h0, 2'h1, 2'h0));
    $display("test glb done");
  endtask

  task t_s2c;
    wr_reg(OFF_S2C, 32'h40003C00);
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h5, 4'hA, 2'h0, 2'h3, 2'h0));
    wr_reg(OFF_S2C, 32'h00000030);
    wr_reg(OFF_S1CTL, 32'h00000000);
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'hA, 2'h0, 2'h1, 2'h2));
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h1, 1'h0, mk(3'h7, 4'hA, 2'h0, 2'h1, 2'h0));
    $display("test s2c done");
  endtask

  task t_s1;
    wr_reg(OFF_S2C, 32'h00000000);
    wr_reg(OFF_S1CTL, 32'h80000000);
    setd(mk(3'h7, 4'hF, 2'h0, 2'h3, 2'h0), 21'h000000);
    tx(mk(3'h7, 4'h5, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'hF, 2'h0, 2'h3, 2'h0));
    wr_reg(OFF_CBAR, 32'h000A2C00);
    tx(mk(3'h7, 4'h5, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h5, 4'hA, 2'h0, 2'h2, 2'h0));
    wr_reg(OFF_CBAR, 32'h00053000);
    tx(mk(3'h7, 4'h5, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'h5, 2'h0, 2'h1, 2'h0));
    wr_reg(OFF_CBAR, RST_CBAR);
    wr_reg(OFF_S1CTL, 32'h001A3000);
    tx(mk(3'h7, 4'h5, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'hA, 2'h0, 2'h3, 2'h0));
    $display("test s1 done");
  endtask

  task t_s2;
    wr_reg(OFF_S2C, 32'h00002000);
    wr_reg(OFF_CBAR, 32'h40000000);
    wr_reg(OFF_S2CTL, 32'h80000000);
    setd(mk(3'h7, 4'hF, 2'h0, 2'h3, 2'h0), 21'h00B000);
    tx(mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'h0, 2'h2, 2'h1, 2'h0));
    tx(mk(3'h7, 4'h0, 2'h1, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'h0, 2'h1, 2'h1, 2'h0));
    tx(mk(3'h7, 4'h0, 2'h3, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'h0, 2'h2, 2'h1, 2'h0));
    wr_reg(OFF_S2CTL, 32'h000F3800);
    tx(mk(3'h5, 4'hA, 2'h0, 2'h2, 2'h0), 1'h0, 1'h0, 1'h0, mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0));
    $display("test s2 done");
  endtask

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is under a hundred cycles; thirty times that is a hang
  initial begin
    #(25 * 3000);
    mismatches++;
    finish_test;
  end

  initial begin
    rst = 1'h1;
    clk_en = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = '0;
    wdata = 32'h00000000;
    tv = 1'h0;
    tattr = '0;
    tsec = 1'h0;
    twr = 1'h0;
    byp = 1'h0;
    s1d = '0;
    s2d = '0;
    mismatches = 0;
    n_compared = 0;
    n_txn = 0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_glb;
    t_s2c;
    t_s1;
    t_s2;
    // the sink counts one edge after the last output appears
    @(posedge clk);
    #1;
    chk({16'h0000, seen}, n_txn);
    chk({18'h0, last}, {18'h0, mk(3'h7, 4'hA, 2'h0, 2'h2, 2'h0)});
    finish_test;
  end
endmodule
